// >>> tc16_pkg.sv
/*
  tc16_pkg: shared constants of the sixteen-bit timer with capture.
  Register indices, field positions, reset values, clock-select codes and
  prescaler taps. Assumes a byte-wide register port on the CPU side.
*/
package tc16_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices on the byte-wide port
  localparam logic [3:0] ADDR_CTL_ONE  = 4'h0;
  localparam logic [3:0] ADDR_CTL_TWO  = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO   = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI   = 4'h3;
  localparam logic [3:0] ADDR_CAP_LO   = 4'h4;
  localparam logic [3:0] ADDR_CAP_HI   = 4'h5;
  localparam logic [3:0] ADDR_CMPA_LO  = 4'h6;
  localparam logic [3:0] ADDR_CMPA_HI  = 4'h7;
  localparam logic [3:0] ADDR_CMPB_LO  = 4'h8;
  localparam logic [3:0] ADDR_CMPB_HI  = 4'h9;
  localparam logic [3:0] ADDR_FLAG     = 4'ha;
  localparam logic [3:0] ADDR_MASK     = 4'hb;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CTL2_NOISE_BIT  = 7;
  localparam int CTL2_EDGE_BIT   = 6;
  localparam int CTL2_RSVD_BIT   = 5;
  localparam int CTL1_SRC_BIT    = 2;
  localparam int FLAG_OVF_BIT    = 0;
  localparam int FLAG_CMPA_BIT   = 1;
  localparam int FLAG_CMPB_BIT   = 2;
  localparam int FLAG_CAP_BIT    = 5;
  localparam logic [7:0] CTL2_WR_MASK = 8'hdf;
  localparam logic [7:0] FLAG_MASK    = 8'h27;

  ////////////////////////////////////////////////////////////////////////////
  // counter limits
  localparam logic [15:0] CNT_BOTTOM  = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [15:0] TOP_8BIT    = 16'h00ff;
  localparam logic [15:0] TOP_9BIT    = 16'h01ff;
  localparam logic [15:0] TOP_10BIT   = 16'h03ff;

  ////////////////////////////////////////////////////////////////////////////
  // clock-select codes and prescaler taps (mask of low divider bits)
  localparam logic [2:0] CS_STOP      = 3'h0;
  localparam logic [2:0] CS_DIV1      = 3'h1;
  localparam logic [2:0] CS_DIV8      = 3'h2;
  localparam logic [2:0] CS_DIV64     = 3'h3;
  localparam logic [2:0] CS_DIV256    = 3'h4;
  localparam logic [2:0] CS_DIV1024   = 3'h5;
  localparam logic [2:0] CS_EXT_FALL  = 3'h6;
  localparam logic [2:0] CS_EXT_RISE  = 3'h7;
  localparam logic [9:0] TAP_DIV8     = 10'h007;
  localparam logic [9:0] TAP_DIV64    = 10'h03f;
  localparam logic [9:0] TAP_DIV256   = 10'h0ff;
  localparam logic [9:0] TAP_DIV1024  = 10'h3ff;

  ////////////////////////////////////////////////////////////////////////////
  // filter
  localparam int NOISE_SAMPLES = 4;

endpackage : tc16_pkg

// >>> tc_pin_filter.sv
/*
  tc_pin_filter: three-stage synchroniser for an asynchronous pin with an
  optional majority-free noise canceler. Assumes mclk is the io clock.
*/
`timescale 1ns/1ps
module tc_pin_filter
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic pin,
  input  wire logic noise_cancel,
  output logic      level
);

  logic                                   sync_a;
  logic                                   sync_b;
  logic                                   sync_c;
  logic                                   clean;
  logic [tc16_pkg::NOISE_SAMPLES-1:0]     hist;
  wire                                    agree;
  wire                                    all_one;
  wire                                    all_zero;
  wire                                    next_level;

  ////////////////////////////////////////////////////////////////////////////
  // a change counts only once the second and third stage agree
  assign agree    = (sync_b == sync_c);
  assign all_one  = &hist;
  assign all_zero = ~|hist;
  assign next_level = !noise_cancel ? clean :
                      all_one       ? 1'b1  :
                      all_zero      ? 1'b0  : level;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      clean  <= 1'b0;
      hist   <= '0;
      level  <= 1'b0;
    end
    else
    begin
      sync_a <= pin;
      sync_b <= sync_a;
      sync_c <= sync_b;
      if (agree)
        clean <= sync_c;
      // four equal samples needed, which delays capture by four cycles
      hist  <= {hist[tc16_pkg::NOISE_SAMPLES-2:0], clean};
      level <= next_level;
    end
  end

endmodule : tc_pin_filter

// >>> tc_timer16.sv
/*
  tc_timer16: sixteen-bit timer/counter with prescaler, external count pin,
  double-buffered compare and input capture, byte-wide CPU register port.
  Assumes the CPU port is synchronous to mclk (the io clock) and that the
  waveform generator sits outside and reads the forwarded mode bits.
*/
// Operation
// [R1] one shared high-byte holding register for all sixteen-bit registers
// [R2] low-byte write loads held high byte and written low byte together
// [R3] low-byte read copies the high byte into the holding register
// [R4] compare registers read directly, holding register untouched
// [R5] software writes high then low, reads low then high
// [R6] bottom is 0x0000, absolute maximum is 0xffff
// [R7] top is 0x00ff, 0x01ff, 0x03ff, compare a or capture by mode
// [R8] compare a as top in pwm is double buffered
// [R9] compare values checked continuously, match sets the flag
// [R10] clock select zero stops; 1..5 pick io clock over 1,8,64,256,1024
// [R11] code 6 counts falling, code 7 rising edges of the count pin
// [R12] count pin edges count even when the pin is an output
// [R13] noise canceler needs four equal samples before the input changes
// [R14] edge select zero means falling edge, one means rising edge
// [R15] capture copies the counter and sets the capture flag
// [R16] no capture while the capture register is top
// [R17] capture source is the capture pin or the comparator output
// [R18] all requests visible in the flag register and individually masked
// [R19] bit 5 of control two reads zero; software writes zero
// [R20] waveform-mode bits stored and forwarded to the waveform generator
`timescale 1ns/1ps
module tc_timer16
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       capture_pin,
  input  wire logic       comparator_out,
  input  wire logic       external_count_pin,
  output logic      [3:0] wave_mode_bits,
  output logic      [3:0] compare_out_mode,
  output logic            match_a_pulse,
  output logic            match_b_pulse,
  output logic      [7:0] timer_irq_req
);

  logic [7:0]  timer_control_one;
  logic [7:0]  timer_control_two;
  logic [7:0]  timer_flag_reg;
  logic [7:0]  timer_mask_reg;
  logic [7:0]  high_hold;
  logic [15:0] count_value;
  logic [15:0] capture_value;
  logic [15:0] compare_buf_a;
  logic [15:0] compare_buf_b;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [9:0]  prescale;
  logic        count_down;
  logic        match_block;
  logic        cap_level;
  logic        cap_level_d;
  logic        ext_level;
  logic        ext_level_d;

  ////////////////////////////////////////////////////////////////////////////
  // mode decoding, used by top selection, buffering and flag logic

  function automatic logic [15:0] tc_top_of(input logic [3:0] m,
                                             input logic [15:0] cmp_a,
                                             input logic [15:0] cap);
    unique case (m)
      4'h1, 4'h5: tc_top_of = tc16_pkg::TOP_8BIT;
      4'h2, 4'h6: tc_top_of = tc16_pkg::TOP_9BIT;
      4'h3, 4'h7: tc_top_of = tc16_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: tc_top_of = cmp_a;
      4'h8, 4'ha, 4'hc, 4'he: tc_top_of = cap;
      default: tc_top_of = tc16_pkg::CNT_MAX;
    endcase
  endfunction : tc_top_of

  function automatic logic tc_dual_slope(input logic [3:0] m);
    tc_dual_slope = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
  endfunction : tc_dual_slope

  function automatic logic tc_buffered(input logic [3:0] m);
    tc_buffered = !(m inside {4'h0, 4'h4, 4'hc, 4'hd});
  endfunction : tc_buffered

  function automatic logic tc_top_is_cap(input logic [3:0] m);
    tc_top_is_cap = (m inside {4'h8, 4'ha, 4'hc, 4'he});
  endfunction : tc_top_is_cap

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire [3:0]  wave_mode   = {timer_control_two[4:3], timer_control_one[1:0]};
  wire [2:0]  clock_select_field = timer_control_two[2:0];
  wire        capture_noise_cancel = timer_control_two[tc16_pkg::CTL2_NOISE_BIT];
  wire        capture_edge_select  = timer_control_two[tc16_pkg::CTL2_EDGE_BIT];
  wire        mode_dual   = tc_dual_slope(wave_mode);
  wire        mode_buf    = tc_buffered(wave_mode);
  wire        mode_captop = tc_top_is_cap(wave_mode);
  // [R7] top per mode
  wire [15:0] top_value   = tc_top_of(wave_mode, compare_value_a, capture_value);

  wire wr_ctl1  = reg_wr && (reg_addr == tc16_pkg::ADDR_CTL_ONE);
  wire wr_ctl2  = reg_wr && (reg_addr == tc16_pkg::ADDR_CTL_TWO);
  wire wr_cntl  = reg_wr && (reg_addr == tc16_pkg::ADDR_CNT_LO);
  wire wr_capl  = reg_wr && (reg_addr == tc16_pkg::ADDR_CAP_LO);
  wire wr_cmpal = reg_wr && (reg_addr == tc16_pkg::ADDR_CMPA_LO);
  wire wr_cmpbl = reg_wr && (reg_addr == tc16_pkg::ADDR_CMPB_LO);
  wire wr_flag  = reg_wr && (reg_addr == tc16_pkg::ADDR_FLAG);
  wire wr_mask  = reg_wr && (reg_addr == tc16_pkg::ADDR_MASK);
  wire wr_high  = reg_wr && (reg_addr inside {tc16_pkg::ADDR_CNT_HI,
                  tc16_pkg::ADDR_CAP_HI, tc16_pkg::ADDR_CMPA_HI, tc16_pkg::ADDR_CMPB_HI});
  wire rd_cntl  = reg_rd && (reg_addr == tc16_pkg::ADDR_CNT_LO);
  wire rd_capl  = reg_rd && (reg_addr == tc16_pkg::ADDR_CAP_LO);
  // [R2] full word from held high byte and written low byte
  wire [15:0] wr_word = {high_hold, reg_wdata};

  ////////////////////////////////////////////////////////////////////////////
  // clock select: prescaler taps and count pin edges

  wire ext_rise = ext_level && !ext_level_d;
  wire ext_fall = !ext_level && ext_level_d;
  // [R10] stop or io clock over a prescaler tap
  // [R11] count pin edge selection
  wire tick =
    (clock_select_field == tc16_pkg::CS_DIV1) ||
    ((clock_select_field == tc16_pkg::CS_DIV8) && ((prescale & tc16_pkg::TAP_DIV8)
      == tc16_pkg::TAP_DIV8)) ||
    ((clock_select_field == tc16_pkg::CS_DIV64) && ((prescale & tc16_pkg::TAP_DIV64)
      == tc16_pkg::TAP_DIV64)) ||
    ((clock_select_field == tc16_pkg::CS_DIV256) && ((prescale & tc16_pkg::TAP_DIV256)
      == tc16_pkg::TAP_DIV256)) ||
    ((clock_select_field == tc16_pkg::CS_DIV1024) && (prescale == tc16_pkg::TAP_DIV1024)) ||
    ((clock_select_field == tc16_pkg::CS_EXT_FALL) && ext_fall) ||
    ((clock_select_field == tc16_pkg::CS_EXT_RISE) && ext_rise);

  ////////////////////////////////////////////////////////////////////////////
  // counting sequence

  // [R6] bottom and max limits
  wire at_top    = (count_value == top_value);
  wire at_bottom = (count_value == tc16_pkg::CNT_BOTTOM);
  wire at_max    = (count_value == tc16_pkg::CNT_MAX);
  wire turn_down = mode_dual && !count_down && at_top;
  wire turn_up   = mode_dual && count_down && at_bottom;
  wire next_down = turn_down ? 1'b1 : (turn_up ? 1'b0 : count_down);
  wire [15:0] next_count =
    (!mode_dual && at_top) ? tc16_pkg::CNT_BOTTOM :
    next_down ? count_value - 16'h0001 : count_value + 16'h0001;

  // buffered compare values move over at top, or at bottom in modes 8 and 9
  wire reload_at_bottom = (wave_mode inside {4'h8, 4'h9});
  wire buf_update = tick && (reload_at_bottom ? (count_down && at_bottom) : at_top);

  // [R9] continuous compare of both active values
  wire hit_a = tick && !match_block && (count_value == compare_value_a);
  wire hit_b = tick && !match_block && (count_value == compare_value_b);
  wire hit_ovf = tick && (mode_dual ? turn_up :
                 (wave_mode == 4'h0) ? at_max : at_top);

  ////////////////////////////////////////////////////////////////////////////
  // capture trigger

  // [R17] capture from pin or comparator
  wire cap_source = timer_control_one[tc16_pkg::CTL1_SRC_BIT] ? comparator_out : capture_pin;
  // [R14] edge select
  wire cap_edge = capture_edge_select ? (cap_level && !cap_level_d)
                                      : (!cap_level && cap_level_d);
  // [R16] capture disabled while capture register is top
  wire cap_trig = cap_edge && !mode_captop;

  wire [7:0] flag_set = {2'b00, cap_trig, 2'b00, hit_b, hit_a, hit_ovf};
  wire [7:0] flag_clr = wr_flag ? (reg_wdata & tc16_pkg::FLAG_MASK) : 8'h00;
  // event in the clearing cycle survives: set wins
  wire [7:0] next_flags = (timer_flag_reg & ~flag_clr) | flag_set;
  // a mask write takes effect on the request lines at the same edge
  wire [7:0] next_mask = wr_mask ? (reg_wdata & tc16_pkg::FLAG_MASK) : timer_mask_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  // [R4] compare bytes read directly, hold byte used for count and capture
  wire [7:0] next_rdata =
    (reg_addr == tc16_pkg::ADDR_CTL_ONE) ? timer_control_one :
    (reg_addr == tc16_pkg::ADDR_CTL_TWO) ? timer_control_two :
    (reg_addr == tc16_pkg::ADDR_CNT_LO)  ? count_value[7:0] :
    (reg_addr == tc16_pkg::ADDR_CAP_LO)  ? capture_value[7:0] :
    (reg_addr == tc16_pkg::ADDR_CNT_HI)  ? high_hold :
    (reg_addr == tc16_pkg::ADDR_CAP_HI)  ? high_hold :
    (reg_addr == tc16_pkg::ADDR_CMPA_LO) ? compare_buf_a[7:0] :
    (reg_addr == tc16_pkg::ADDR_CMPA_HI) ? compare_buf_a[15:8] :
    (reg_addr == tc16_pkg::ADDR_CMPB_LO) ? compare_buf_b[7:0] :
    (reg_addr == tc16_pkg::ADDR_CMPB_HI) ? compare_buf_b[15:8] :
    (reg_addr == tc16_pkg::ADDR_FLAG)    ? timer_flag_reg :
    (reg_addr == tc16_pkg::ADDR_MASK)    ? timer_mask_reg : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // input filters

  // [R13] filtered capture input
  tc_pin_filter u_cap_filter
  (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .pin          (cap_source),
    .noise_cancel (capture_noise_cancel),
    .level        (cap_level)
  );

  // [R12] pin is sampled regardless of its direction
  tc_pin_filter u_ext_filter
  (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .pin          (external_count_pin),
    .noise_cancel (1'b0),
    .level        (ext_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control, flags, holding register, read data

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      timer_control_one <= tc16_pkg::RST_BYTE;
      timer_control_two <= tc16_pkg::RST_BYTE;
      timer_flag_reg    <= tc16_pkg::RST_BYTE;
      timer_mask_reg    <= tc16_pkg::RST_BYTE;
      high_hold         <= tc16_pkg::RST_BYTE;
      reg_rdata         <= tc16_pkg::RST_BYTE;
      timer_irq_req     <= tc16_pkg::RST_BYTE;
    end
    else
    begin
      if (wr_ctl1)
        timer_control_one <= reg_wdata;
      // [R19] reserved bit stays zero
      if (wr_ctl2)
        timer_control_two <= reg_wdata & tc16_pkg::CTL2_WR_MASK;
      timer_mask_reg <= next_mask;
      timer_flag_reg <= next_flags;
      // [R18] per-flag mask onto the request lines
      timer_irq_req  <= next_flags & next_mask;
      // [R1] single shared holding register
      // [R3] low-byte read copies high byte in the same cycle
      if (wr_high)
        high_hold <= reg_wdata;
      else if (rd_cntl)
        high_hold <= count_value[15:8];
      else if (rd_capl)
        high_hold <= capture_value[15:8];
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, prescaler and edge history

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      count_value <= tc16_pkg::RST_WORD;
      count_down  <= 1'b0;
      match_block <= 1'b0;
      prescale    <= '0;
      cap_level_d <= 1'b0;
      ext_level_d <= 1'b0;
    end
    else
    begin
      prescale    <= prescale + 10'h001;
      cap_level_d <= cap_level;
      ext_level_d <= ext_level;
      // a count write blocks the match on the next timer clock
      if (wr_cntl)
      begin
        count_value <= wr_word;
        match_block <= 1'b1;
      end
      else if (tick)
      begin
        count_value <= next_count;
        count_down  <= next_down;
        match_block <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare and capture registers

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      compare_buf_a   <= tc16_pkg::RST_WORD;
      compare_buf_b   <= tc16_pkg::RST_WORD;
      compare_value_a <= tc16_pkg::RST_WORD;
      compare_value_b <= tc16_pkg::RST_WORD;
      capture_value   <= tc16_pkg::RST_WORD;
    end
    else
    begin
      if (wr_cmpal)
        compare_buf_a <= wr_word;
      if (wr_cmpbl)
        compare_buf_b <= wr_word;
      // [R8] pwm modes take the new value only at the update point
      if (!mode_buf || buf_update)
      begin
        compare_value_a <= wr_cmpal ? wr_word : compare_buf_a;
        compare_value_b <= wr_cmpbl ? wr_word : compare_buf_b;
      end
      // [R15] capture copies the counter
      if (cap_trig)
        capture_value <= count_value;
      else if (wr_capl)
        capture_value <= wr_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // forwarded outputs

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wave_mode_bits   <= 4'h0;
      compare_out_mode <= 4'h0;
      match_a_pulse    <= 1'b0;
      match_b_pulse    <= 1'b0;
    end
    else
    begin
      // [R20] mode bits forwarded to the waveform generator
      wave_mode_bits   <= wave_mode;
      compare_out_mode <= timer_control_one[7:4];
      match_a_pulse    <= hit_a;
      match_b_pulse    <= hit_b;
    end
  end

endmodule : tc_timer16

// >>> tc_timer16_checker.sv
/* tc_timer16_checker: port-level properties of the sixteen-bit timer.
   assumes one clock domain, mclk, with synchronous active-low rst_n. */
`timescale 1ns/1ps
module tc_timer16_checker
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       capture_pin,
  input wire logic       comparator_out,
  input wire logic       external_count_pin,
  input wire logic [3:0] wave_mode_bits,
  input wire logic [3:0] compare_out_mode,
  input wire logic       match_a_pulse,
  input wire logic       match_b_pulse,
  input wire logic [7:0] timer_irq_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////
  property p_rdata_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  property p_cmpa_direct;
    reg_wr && reg_addr == 4'h7 ##1 reg_wr && reg_addr == 4'h6 ##1 reg_rd && reg_addr == 4'h7
    |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_cmpa_direct: assert property (p_cmpa_direct) else $error("compare readback");
  property p_rsvd; reg_rd && reg_addr == 4'h1 |=> !reg_rdata[5]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_flag_bits; reg_rd && reg_addr == 4'ha |=> (reg_rdata & 8'hd8) == 8'h00; endproperty
  a_flag_bits: assert property (p_flag_bits) else $error("unused flag bit");
  property p_irq_masked; reg_wr && reg_addr == 4'hb && reg_wdata == 8'h00 |=> timer_irq_req == 8'h00;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked request");
  property p_irq_legal; (timer_irq_req & 8'hd8) == 8'h00; endproperty
  a_irq_legal: assert property (p_irq_legal) else $error("unused request bit");
  property p_wave_hi; reg_wr && reg_addr == 4'h1 |=> ##1 wave_mode_bits[3:2] == $past(reg_wdata[4:3], 2);
  endproperty
  a_wave_hi: assert property (p_wave_hi) else $error("mode bits lost");
  property p_ctl_one;
    reg_wr && reg_addr == 4'h0 |=> ##1 compare_out_mode == $past(reg_wdata[7:4], 2)
      && wave_mode_bits[1:0] == $past(reg_wdata[1:0], 2);
  endproperty
  a_ctl_one: assert property (p_ctl_one) else $error("control one lost");
  c_match_a: cover property (match_a_pulse);
  c_match_b: cover property (match_b_pulse);
  c_cap_req: cover property (timer_irq_req[5]);
endmodule : tc_timer16_checker
bind tc_timer16 tc_timer16_checker u_chk (.*);

// >>> tc_pin_model.sv
/* tc_pin_model: drives the capture, comparator and count pins.
   assumes idle-high pins and callers that start 1 ns after mclk rises. */
`timescale 1ns/1ps
module tc_pin_model
(
  input  wire logic mclk,
  output logic      cap_pin,
  output logic      cmp_out,
  output logic      cnt_pin
);
  initial
  begin
    cap_pin = 1'b1;
    cmp_out = 1'b1;
    cnt_pin = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : hold
  // wide levels so every edge survives the synchroniser
  task automatic count_edges(input int n);
    repeat (n)
    begin
      cnt_pin = 1'b0;
      hold(6);
      cnt_pin = 1'b1;
      hold(6);
    end
  endtask : count_edges
  task automatic drive_cap(input logic comp, input logic v, input int n);
    if (comp)
      cmp_out = v;
    else
      cap_pin = v;
    hold(n);
  endtask : drive_cap
endmodule : tc_pin_model

// >>> tc_timer16_tb_top.sv
/* tc_timer16_tb_top: self-checking bench of the timer against expected values worked out in the test itself.
   assumes the pin model owns the three asynchronous inputs. */
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tc_timer16_tb_top;
  logic        mclk, rst_n, reg_wr, reg_rd, cap_pin, cmp_out, cnt_pin;
  logic [3:0]  reg_addr, wave_mode_bits, compare_out_mode;
  logic [7:0]  reg_wdata, reg_rdata, timer_irq_req;
  logic [31:0] lfsr;
  logic [15:0] c16, v16;
  logic [6:0]  cap_tab[6] = '{7'h01, 7'h21, 7'h61, 7'h38, 7'h11, 7'h26};
  int          div_q[$] = '{1, 8, 64, 256, 1024};
  int          n, fail_count, tests_run;
  tc_timer16 dut
  (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .capture_pin(cap_pin),
    .comparator_out(cmp_out), .external_count_pin(cnt_pin), .wave_mode_bits(wave_mode_bits),
    .compare_out_mode(compare_out_mode), .match_a_pulse(), .match_b_pulse(),
    .timer_irq_req(timer_irq_req)
  );
  tc_pin_model pins (.mclk(mclk), .cap_pin(cap_pin), .cmp_out(cmp_out), .cnt_pin(cnt_pin));
  always #2.5 mclk = ~mclk;
  ////////////////////////
  task automatic test_done;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  function automatic logic [15:0] rnd16;
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction : rnd16
  // strobes hold until the next call
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
    reg_wr = w;
    reg_rd = r;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
  endtask : bus
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr8
  task automatic rd8(input logic [3:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd8
  task automatic idle(input int k);
    repeat (k) bus(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : idle
  // high byte first on writes, low byte first on reads
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr8(lo + 4'h1, v[15:8]);
    wr8(lo, v[7:0]);
  endtask : wr16
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd8(lo);
    v[7:0] = reg_rdata;
    rd8(lo + 4'h1);
    v[15:8] = reg_rdata;
  endtask : rd16
  task automatic run_ext(input logic [15:0] start, input logic [7:0] code, input int k);
    wr16(tc16_pkg::ADDR_CNT_LO, start);
    wr8(tc16_pkg::ADDR_CTL_TWO, code);
    idle(1);
    pins.count_edges(k);
    idle(8);
    wr8(tc16_pkg::ADDR_CTL_TWO, 8'h00);
    rd16(tc16_pkg::ADDR_CNT_LO, v16);
  endtask : run_ext
  ////////////////////////
  initial
  begin
    repeat (40000) @(posedge mclk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end
  initial
  begin
    {mclk, rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    lfsr = 32'hda200de3;
    fail_count = 0;
    tests_run = 0;
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (int a = 0; a < 16; a++)
    begin
      rd8(a[3:0]);
      `CHK("reset or unmapped read", 8'h00, reg_rdata)
    end
    wr8(tc16_pkg::ADDR_CTL_ONE, 8'hf3);
    wr8(tc16_pkg::ADDR_CTL_TWO, 8'hf8);
    wr8(4'hc, 8'hff);
    rd8(tc16_pkg::ADDR_CTL_TWO);
    `CHK("control two", 8'hd8, reg_rdata)
    `CHK("wave mode", 4'hf, wave_mode_bits)
    `CHK("out mode", 4'hf, compare_out_mode)
    rd8(4'hc);
    `CHK("unmapped", 8'h00, reg_rdata)
    wr8(tc16_pkg::ADDR_CTL_ONE, 8'h00);
    wr8(tc16_pkg::ADDR_CTL_TWO, 8'h00);
    $display("test control done");
    c16 = rnd16();
    wr16(tc16_pkg::ADDR_CMPA_LO, c16);
    rd8(tc16_pkg::ADDR_CMPA_HI);
    `CHK("compare a high", c16[15:8], reg_rdata)
    c16 = rnd16();
    wr8(tc16_pkg::ADDR_CMPB_HI, c16[15:8]);
    wr8(tc16_pkg::ADDR_CNT_LO, c16[7:0]);
    rd16(tc16_pkg::ADDR_CNT_LO, v16);
    `CHK("shared hold count", c16, v16)
    c16 = rnd16() | 16'h00ff;
    wr16(tc16_pkg::ADDR_CNT_LO, c16);
    rd8(tc16_pkg::ADDR_CNT_LO);
    wr8(tc16_pkg::ADDR_CTL_TWO, 8'h07);
    idle(1);
    pins.count_edges(1);
    idle(8);
    wr8(tc16_pkg::ADDR_CTL_TWO, 8'h00);
    rd8(tc16_pkg::ADDR_CMPA_LO);
    rd8(tc16_pkg::ADDR_CMPA_HI);
    rd8(tc16_pkg::ADDR_CNT_HI);
    `CHK("latched high byte", c16[15:8], reg_rdata)
    $display("test byte access done");
    for (int k = 6; k < 8; k++)
    begin
      c16 = rnd16() & 16'h7fff;
      n = int'(lfsr[2:0]) + 1;
      run_ext(c16, k[7:0], n);
      `CHK("pin count", c16 + n[15:0], v16)
    end
    c16 = rnd16() & 16'h7fff;
    wr16(tc16_pkg::ADDR_CMPA_LO, c16 + 16'h0002);
    wr16(tc16_pkg::ADDR_CMPB_LO, c16 + 16'h0005);
    wr8(tc16_pkg::ADDR_FLAG, 8'h27);
    wr8(tc16_pkg::ADDR_MASK, 8'h06);
    run_ext(c16, 8'h07, 6);
    rd8(tc16_pkg::ADDR_FLAG);
    `CHK("match flags", 8'h06, reg_rdata)
    `CHK("match requests", 8'h06, timer_irq_req)
    wr8(tc16_pkg::ADDR_MASK, 8'h00);
    `CHK("masked requests", 8'h00, timer_irq_req)
    wr8(tc16_pkg::ADDR_FLAG, 8'h06);
    run_ext(16'hffff, 8'h07, 1);
    `CHK("wrap to bottom", 16'h0000, v16)
    rd8(tc16_pkg::ADDR_FLAG);
    `CHK("overflow flag", 8'h01, reg_rdata)
    $display("test compare done");
    foreach (div_q[i])
    begin
      wr16(tc16_pkg::ADDR_CNT_LO, 16'h0000);
      wr8(tc16_pkg::ADDR_CTL_TWO, 8'(i + 1));
      idle(4096);
      wr8(tc16_pkg::ADDR_CTL_TWO, 8'h00);
      rd16(tc16_pkg::ADDR_CNT_LO, v16);
      n = 4096 / div_q[i];
      `CHK("prescaled count", 1'b1, (v16 >= n - 2 && v16 <= n + 2))
    end
    c16 = v16;
    idle(40);
    rd16(tc16_pkg::ADDR_CNT_LO, v16);
    `CHK("stopped count", c16, v16)
    $display("test prescaler done");
    wr8(tc16_pkg::ADDR_MASK, 8'h20);
    foreach (cap_tab[i])
    begin
      c16 = rnd16();
      wr16(tc16_pkg::ADDR_CNT_LO, c16);
      wr8(tc16_pkg::ADDR_CTL_ONE, {5'h00, cap_tab[i][6], 2'h0});
      wr8(tc16_pkg::ADDR_CTL_TWO, {cap_tab[i][4], cap_tab[i][5], 1'b0, cap_tab[i][2:1], 3'h0});
      idle(1);
      pins.drive_cap(cap_tab[i][6], !cap_tab[i][5], 12);
      wr8(tc16_pkg::ADDR_FLAG, 8'h20);
      idle(1);
      pins.drive_cap(cap_tab[i][6], cap_tab[i][5], cap_tab[i][3] ? 3 : 16);
      pins.drive_cap(cap_tab[i][6], !cap_tab[i][5], 16);
      rd8(tc16_pkg::ADDR_FLAG);
      `CHK("capture flag", cap_tab[i][0], reg_rdata[5])
      `CHK("capture request", {2'h0, cap_tab[i][0], 5'h00}, timer_irq_req)
      rd16(tc16_pkg::ADDR_CAP_LO, v16);
      if (cap_tab[i][0])
        `CHK("capture value", c16, v16)
    end
    $display("test capture done");
    test_done();
  end
endmodule : tc_timer16_tb_top
